// >>> verilog/afc_frame_classifier.sv
// Access list: entry table, first-hit classification, actions and hit counters.
//
// Operation
// - Entry matches all ports or one port
// - Specific policy filter compares policy value
// - Policy mask bits select compared bits
// - One frame type per entry; any matches all
// - Ethernet type needs length/type at least 0600
// - ARP entry matches ARP, IPv4 matches IPv4
// - ARP and IPv4 never hit Ethernet type
// - Deny drops; permit applies remaining operations
// - Optional rate limiter one of sixteen
// - Policer enable and identifier one to 128
// - Valid redirect port replaces normal forwarding
// - Mirror option copies matching frames
// - Logging reports matches to limited log path
// - Shutdown disables the frame's ingress port
// - Hit counter increments per matching frame
// - Clear command zeroes all hit counters except one hit in the same cycle, set to one
// - Source filter only for Ethernet type, ARP
// - Destination filter: any, group, all, single cast
// - Up to 256 entries; reserved ones first
`timescale 1ns/100ps

module afc_frame_classifier
  import afc_pkg::*;
#(
  parameter int NUM_ENTRIES = 256,
  parameter int NUM_RSVD    = 4,
  parameter int NUM_PORTS   = 32,
  parameter int CNT_W       = 32,
  parameter int IDX_W       = $clog2(NUM_ENTRIES)
)
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              cfgWe,
  input  wire logic              cfgInternal,
  input  wire logic [IDX_W-1:0]  cfgIdx,
  input  wire afc_entry_s        cfgEntry,
  input  wire logic              cfgRemoveAll,
  input  wire logic              cntClear,
  input  wire logic [IDX_W-1:0]  cntRdIdx,
  output logic      [CNT_W-1:0]  cntRdData,
  input  wire logic              frmValid,
  input  wire afc_frame_s        frmHdr,
  input  wire logic              logReady,
  output logic                   resValid,
  output logic                   resHit,
  output logic      [IDX_W-1:0]  resIdx,
  output afc_action_s            resAct,
  output logic                   logLost
);

  afc_entry_s             entryTab_r [NUM_ENTRIES];
  logic       [CNT_W-1:0] hitCnt_r   [NUM_ENTRIES];
  logic [NUM_ENTRIES-1:0] matchVec;
  logic                   hitAny;
  logic       [IDX_W-1:0] hitIdx;
  afc_entry_s             hitEntry;
  afc_action_s            act_nxt;
  logic                   logLost_nxt;
  logic                   resValid_r;
  logic                   resHit_r;
  logic       [IDX_W-1:0] resIdx_r;
  afc_action_s            resAct_r;
  logic                   logLost_r;
  logic       [CNT_W-1:0] cntRdData_r;

  // Decides whether one entry matches one frame header.
  function automatic logic entryHit(input afc_entry_s e, input afc_frame_s f);
    logic portOk;
    logic polOk;
    logic typeOk;
    logic srcOk;
    logic dstOk;
    logic isGroup;
    logic isAll;
    begin
      portOk = e.portAny || (e.port == f.port);
      polOk  = !e.polSpecific || (((f.policy ^ e.polVal) & e.polMask) == POL_ZERO);
      case (e.ftype)
        FT_ANY:   typeOk = 1'b1;
        FT_ETYPE: typeOk = (f.lenType >= ETYPE_MIN) && !f.isArp && !f.isIpv4;
        FT_ARP:   typeOk = f.isArp;
        FT_IPV4:  typeOk = f.isIpv4;
        default:  typeOk = 1'b0;
      endcase
      // The source filter has no meaning for other frame kinds and is ignored there.
      srcOk = !(e.srcSpecific && (e.ftype == FT_ETYPE || e.ftype == FT_ARP))
              || (f.sourceStationAddress == e.sourceStationAddress);
      isAll   = (f.destinationStationAddress == MAC_ALL_ONES);
      isGroup = f.destinationStationAddress[GROUP_BIT];
      case (e.dstMode)
        DM_ANY:         dstOk = 1'b1;
        DM_GROUP_CAST:  dstOk = isGroup && !isAll;
        DM_ALL_CAST:    dstOk = isAll;
        DM_SINGLE_CAST: dstOk = !isGroup;
        DM_SPECIFIC:    dstOk = (f.destinationStationAddress == e.destinationStationAddress);
        default:        dstOk = 1'b0;
      endcase
      entryHit = e.valid && portOk && polOk && typeOk && srcOk && dstOk;
    end
  endfunction

  // Entry table; reserved entries sit at the lowest indices and only internal writes reach them.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        entryTab_r[i] <= '0;
      end
    end
    else
    begin
      if (cfgRemoveAll)
      begin
        for (int i = NUM_RSVD; i < NUM_ENTRIES; i++)
        begin
          entryTab_r[i].valid <= 1'b0;
        end
      end
      if (cfgWe && (cfgInternal || (cfgIdx >= IDX_W'(NUM_RSVD))))
      begin
        entryTab_r[cfgIdx] <= cfgEntry;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENTRIES; gi++)
    begin : g_match
      assign matchVec[gi] = entryHit(entryTab_r[gi], frmHdr);
    end
  endgenerate

  // Lowest index wins, so reserved entries take precedence.
  always_comb
  begin
    hitAny = 1'b0;
    hitIdx = '0;
    for (int i = NUM_ENTRIES - 1; i >= 0; i--)
    begin
      if (matchVec[i])
      begin
        hitAny = 1'b1;
        hitIdx = IDX_W'(i);
      end
    end
  end

  assign hitEntry = entryTab_r[hitIdx];

  // A denied frame is dropped; forwarding-side operations only apply when permitted.
  always_comb
  begin
    act_nxt     = '0;
    logLost_nxt = 1'b0;
    if (frmValid && hitAny)
    begin
      act_nxt.drop      = hitEntry.deny;
      act_nxt.rateEn    = !hitEntry.deny && hitEntry.rateEn;
      act_nxt.rateId    = hitEntry.rateId;
      act_nxt.policerEn = !hitEntry.deny && hitEntry.policerEn;
      act_nxt.policerId = hitEntry.policerId;
      act_nxt.redirEn   = !hitEntry.deny && hitEntry.redirEn
                          && (hitEntry.redirPort < PORT_W'(NUM_PORTS));
      act_nxt.redirPort = hitEntry.redirPort;
      act_nxt.mirror    = !hitEntry.deny && hitEntry.mirror;
      act_nxt.log       = hitEntry.log && logReady;
      logLost_nxt       = hitEntry.log && !logReady;
      act_nxt.shutdown  = hitEntry.shutdown;
      act_nxt.shutPort  = frmHdr.port;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resValid_r <= 1'b0;
      resHit_r   <= 1'b0;
      resIdx_r   <= '0;
      resAct_r   <= '0;
      logLost_r  <= 1'b0;
    end
    else
    begin
      resValid_r <= frmValid;
      resHit_r   <= frmValid && hitAny;
      resIdx_r   <= hitIdx;
      resAct_r   <= act_nxt;
      logLost_r  <= logLost_nxt;
    end
  end

  // A hit in the same cycle as a clear leaves that counter at one, so the frame is not lost.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        hitCnt_r[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_ENTRIES; i++)
      begin
        if (frmValid && hitAny && (hitIdx == IDX_W'(i)))
        begin
          hitCnt_r[i] <= cntClear ? CNT_W'(1) : hitCnt_r[i] + CNT_W'(1);
        end
        else if (cntClear)
        begin
          hitCnt_r[i] <= '0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cntRdData_r <= '0;
    end
    else
    begin
      cntRdData_r <= hitCnt_r[cntRdIdx];
    end
  end

  assign resValid  = resValid_r;
  assign resHit    = resHit_r;
  assign resIdx    = resIdx_r;
  assign resAct    = resAct_r;
  assign logLost   = logLost_r;
  assign cntRdData = cntRdData_r;

  a_result_timing: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    frmValid |=> resValid ##1 (!resValid || $past(frmValid)))
  else $error("result valid does not follow frame one cycle later");

  a_deny_drops: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    resAct.drop |-> resHit && !resAct.mirror && !resAct.redirEn && !resAct.rateEn)
  else $error("dropped frame carries forwarding operations");

  a_port_qualify: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny) |-> (hitEntry.portAny || hitEntry.port == frmHdr.port))
  else $error("entry hit on wrong ingress port");

  a_etype_excl: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && hitEntry.ftype == FT_ETYPE)
      |-> (!frmHdr.isArp && !frmHdr.isIpv4 && frmHdr.lenType >= ETYPE_MIN))
  else $error("ethernet type entry hit by ARP, IPv4 or length frame");

  a_policy_mask: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && hitEntry.polSpecific)
      |-> ((frmHdr.policy & hitEntry.polMask) == (hitEntry.polVal & hitEntry.polMask)))
  else $error("policy mismatch on masked bits");

  a_count_hit: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && !cntClear)
      |=> hitCnt_r[resIdx] == $past(hitCnt_r[hitIdx]) + CNT_W'(1))
  else $error("hit counter did not increment by one");

  a_clear_zero: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (cntClear && !frmValid) |=> (hitCnt_r[0] == '0) ##1 (cntRdData == $past(hitCnt_r[cntRdIdx])))
  else $error("counters not cleared or readout stale");

  a_redirect_valid: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    resAct.redirEn |-> resHit && (resAct.redirPort < PORT_W'(NUM_PORTS)))
  else $error("redirect to a port outside the switch");

  a_shutdown_port: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && hitEntry.shutdown)
      |=> resAct.shutdown && resAct.shutPort == $past(frmHdr.port))
  else $error("shutdown not raised for the ingress port");

  a_log_lost: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    logLost |-> !resAct.log && resHit && !$past(logReady))
  else $error("log lost while log path was ready");

  a_first_hit: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny)
      |-> matchVec[hitIdx] && ((matchVec & ~({NUM_ENTRIES{1'b1}} << hitIdx)) == '0))
  else $error("deciding entry is not the first matching entry");

  a_type_select: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny)
      |-> (hitEntry.ftype != FT_ARP || frmHdr.isArp) && (hitEntry.ftype != FT_IPV4 || frmHdr.isIpv4))
  else $error("ARP or IPv4 entry hit by another frame kind");

  a_rate_pass: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && !hitEntry.deny)
      |=> resAct.rateEn == $past(hitEntry.rateEn) && resAct.rateId == $past(hitEntry.rateId))
  else $error("rate limiter not applied as configured");

  a_policer_pass: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && !hitEntry.deny)
      |=> resAct.policerEn == $past(hitEntry.policerEn) && resAct.policerId == $past(hitEntry.policerId))
  else $error("policer not applied as configured");

  a_mirror_pass: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && !hitEntry.deny) |=> resAct.mirror == $past(hitEntry.mirror))
  else $error("mirror option not applied as configured");

  a_source_filter: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny && hitEntry.srcSpecific
      && (hitEntry.ftype == FT_ETYPE || hitEntry.ftype == FT_ARP))
      |-> frmHdr.sourceStationAddress == hitEntry.sourceStationAddress)
  else $error("source address filter let a foreign source hit");

  a_dest_filter: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (frmValid && hitAny)
      |-> (hitEntry.dstMode != DM_ALL_CAST || frmHdr.destinationStationAddress == MAC_ALL_ONES)
        && (hitEntry.dstMode != DM_SPECIFIC
            || frmHdr.destinationStationAddress == hitEntry.destinationStationAddress))
  else $error("destination filter let a wrong destination hit");

  a_reserved_guard: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (cfgWe && !cfgInternal && cfgIdx < IDX_W'(NUM_RSVD))
      |=> entryTab_r[$past(cfgIdx)] == $past(entryTab_r[cfgIdx]))
  else $error("reserved entry changed by an external write");

endmodule

// >>> verilog/afc_pkg.sv
// Shared widths, constants and carrier types of the access list frame classifier.
package afc_pkg;

  localparam int PORT_W    = 6;
  localparam int MAC_W     = 48;
  localparam int POL_W     = 8;
  localparam int RATE_W    = 4;
  localparam int POLICER_W = 7;
  localparam int LT_W      = 16;
  localparam int GROUP_BIT = 40;

  localparam logic [LT_W-1:0]  ETYPE_MIN    = 16'h0600;
  localparam logic [MAC_W-1:0] MAC_ALL_ONES = 48'hFFFF_FFFF_FFFF;
  localparam logic [POL_W-1:0] POL_ZERO     = 8'h00;

  typedef enum logic [1:0] {
    FT_ANY   = 2'h0,
    FT_ETYPE = 2'h1,
    FT_ARP   = 2'h2,
    FT_IPV4  = 2'h3
  } afc_ftype_e;

  typedef enum logic [2:0] {
    DM_ANY         = 3'h0,
    DM_GROUP_CAST  = 3'h1,
    DM_ALL_CAST    = 3'h2,
    DM_SINGLE_CAST = 3'h3,
    DM_SPECIFIC    = 3'h4
  } afc_destination_station_address_e;

  // One access_control_entry; rateId n means limiter n+1, policerId n means policer n+1.
  typedef struct packed {
    logic                 valid;
    logic                 portAny;
    logic [PORT_W-1:0]    port;
    logic                 polSpecific;
    logic [POL_W-1:0]     polVal;
    logic [POL_W-1:0]     polMask;
    afc_ftype_e           ftype;
    logic                 deny;
    logic                 rateEn;
    logic [RATE_W-1:0]    rateId;
    logic                 policerEn;
    logic [POLICER_W-1:0] policerId;
    logic                 redirEn;
    logic [PORT_W-1:0]    redirPort;
    logic                 mirror;
    logic                 log;
    logic                 shutdown;
    logic                 srcSpecific;
    logic [MAC_W-1:0]     sourceStationAddress;
    afc_destination_station_address_e            dstMode;
    logic [MAC_W-1:0]     destinationStationAddress;
  } afc_entry_s;

  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [POL_W-1:0]  policy;
    logic [LT_W-1:0]   lenType;
    logic              isArp;
    logic              isIpv4;
    logic [MAC_W-1:0]  sourceStationAddress;
    logic [MAC_W-1:0]  destinationStationAddress;
  } afc_frame_s;

  typedef struct packed {
    logic                 drop;
    logic                 rateEn;
    logic [RATE_W-1:0]    rateId;
    logic                 policerEn;
    logic [POLICER_W-1:0] policerId;
    logic                 redirEn;
    logic [PORT_W-1:0]    redirPort;
    logic                 mirror;
    logic                 log;
    logic                 shutdown;
    logic [PORT_W-1:0]    shutPort;
  } afc_action_s;

endpackage

// >>> verif/afc_ingress_model.sv
// Behavioural ingress pipeline that hands parsed frame headers to the classifier.
`timescale 1ns/100ps

module afc_ingress_model
  import afc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       sendReq,
  input  wire afc_frame_s sendHdr,
  output logic            frmValid,
  output afc_frame_s      frmHdr
);
  // Between frames the header lines toggle, so a header sampled out of turn never looks valid.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      frmValid <= 1'h0;
      frmHdr   <= '0;
    end
    else if (sendReq)
    begin
      frmValid <= 1'h1;
      frmHdr   <= sendHdr;
    end
    else
    begin
      frmValid <= 1'h0;
      frmHdr   <= ~frmHdr;
    end
  end
endmodule

// >>> verif/afc_frame_classifier_test.sv
// Self-checking bench for the access list frame classifier.
`timescale 1ns/100ps

module afc_frame_classifier_test
  import afc_pkg::*;
;
  logic        ref_clk = 1'h0, nrst = 1'h0, cfgWe = 1'h0, cfgInternal = 1'h0;
  logic        cfgRemoveAll = 1'h0, cntClear = 1'h0, logReady = 1'h1, sendReq = 1'h0;
  logic [7:0]  cfgIdx = 8'h00, cntRdIdx = 8'h00, resIdx;
  afc_entry_s  cfgEntry = '0;
  afc_frame_s  sendHdr = '0, frmHdr;
  logic [31:0] cntRdData;
  logic        frmValid, resValid, resHit, logLost;
  afc_action_s resAct, a;
  int          fails = 0, samples_checked = 0, cyc = 0;

  afc_ingress_model i_afc_ingress_model (.ref_clk(ref_clk), .nrst(nrst), .sendReq(sendReq),
    .sendHdr(sendHdr), .frmValid(frmValid), .frmHdr(frmHdr));
  afc_frame_classifier i_afc_frame_classifier (.ref_clk(ref_clk), .nrst(nrst), .cfgWe(cfgWe),
    .cfgInternal(cfgInternal), .cfgIdx(cfgIdx), .cfgEntry(cfgEntry),
    .cfgRemoveAll(cfgRemoveAll), .cntClear(cntClear), .cntRdIdx(cntRdIdx),
    .cntRdData(cntRdData), .frmValid(frmValid), .frmHdr(frmHdr), .logReady(logReady),
    .resValid(resValid), .resHit(resHit), .resIdx(resIdx), .resAct(resAct),
    .logLost(logLost));

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic afc_entry_s ent(input afc_ftype_e ft);
    afc_entry_s e;
    e = '0;
    e.valid = 1'h1;
    e.portAny = 1'h1;
    e.ftype = ft;
    return e;
  endfunction

  function automatic afc_frame_s frm();
    afc_frame_s f;
    f = '0;
    f.port = 6'h03;
    f.lenType = 16'h88b5;
    f.sourceStationAddress = 48'h0200_0000_0001;
    f.destinationStationAddress = 48'h0200_0000_0002;
    return f;
  endfunction

  task automatic wr(input logic [7:0] idx, input afc_entry_s e, input logic intl);
    @(posedge ref_clk);
    cfgWe <= 1'h1;
    cfgIdx <= idx;
    cfgEntry <= e;
    cfgInternal <= intl;
    @(posedge ref_clk);
    cfgWe <= 1'h0;
    cfgInternal <= 1'h0;
  endtask

  task automatic strobe(input logic ra, input logic cc);
    @(posedge ref_clk);
    cfgRemoveAll <= ra;
    cntClear <= cc;
    @(posedge ref_clk);
    cfgRemoveAll <= 1'h0;
    cntClear <= 1'h0;
  endtask

  // Results stand for one cycle, so callers look at resAct right after this returns.
  task automatic send(input afc_frame_s h, input logic hit, input logic [7:0] idx);
    @(posedge ref_clk);
    sendReq <= 1'h1;
    sendHdr <= h;
    @(posedge ref_clk);
    sendReq <= 1'h0;
    @(posedge ref_clk);
    #1;
    chk("resValid", 48'h1, resValid);
    chk("resHit", hit, resHit);
    if (hit)
      chk("resIdx", idx, resIdx);
  endtask

  task automatic rdCnt(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge ref_clk);
    cntRdIdx <= idx;
    @(posedge ref_clk);
    #1;
    chk("cntRdData", exp, cntRdData);
  endtask

  task automatic t_port();
    afc_entry_s e;
    afc_frame_s f;
    e = ent(FT_ANY);
    e.portAny = 1'h0;
    e.port = 6'h03;
    f = frm();
    wr(8'h0a, e, 1'h0);
    send(f, 1'h1, 8'h0a);
    f.port = 6'h04;
    send(f, 1'h0, 8'h00);
    e.port = 6'h04;
    wr(8'h02, e, 1'h0);
    send(f, 1'h0, 8'h00);
    wr(8'h02, e, 1'h1);
    strobe(1'h1, 1'h0);
    send(f, 1'h1, 8'h02);
    f.port = 6'h03;
    send(f, 1'h0, 8'h00);
    wr(8'h02, '0, 1'h1);
  endtask

  task automatic t_policy();
    afc_entry_s e;
    afc_frame_s f;
    e = ent(FT_ANY);
    e.polSpecific = 1'h1;
    e.polVal = 8'ha5;
    e.polMask = 8'hf0;
    f = frm();
    wr(8'h0a, e, 1'h0);
    f.policy = 8'haf;
    send(f, 1'h1, 8'h0a);
    f.policy = 8'h5f;
    send(f, 1'h0, 8'h00);
  endtask

  task automatic t_ftype();
    afc_ftype_e ft[4] = '{FT_ETYPE, FT_ARP, FT_IPV4, FT_ANY};
    logic [3:0] hits[4] = '{4'h1, 4'h4, 4'h8, 4'hf};
    logic [15:0] lt[4] = '{16'h0600, 16'h05ff, 16'h0806, 16'h0800};
    afc_frame_s f;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h0a, ent(ft[m]), 1'h0);
      for (int k = 0; k < 4; k++)
      begin
        f = frm();
        f.lenType = lt[k];
        f.isArp = (k == 2);
        f.isIpv4 = (k == 3);
        send(f, hits[m][k], 8'h0a);
      end
    end
  endtask

  task automatic t_actions();
    afc_entry_s e;
    e = ent(FT_ANY);
    {e.rateEn, e.rateId, e.policerEn, e.policerId} = {1'h1, 4'h4, 1'h1, 7'h7f};
    {e.redirEn, e.redirPort, e.mirror, e.log} = {1'h1, 6'h05, 1'h1, 1'h1};
    wr(8'h0a, e, 1'h0);
    send(frm(), 1'h1, 8'h0a);
    a = '0;
    {a.rateEn, a.rateId, a.policerEn, a.policerId} = {1'h1, 4'h4, 1'h1, 7'h7f};
    {a.redirEn, a.redirPort, a.mirror, a.log} = {1'h1, 6'h05, 1'h1, 1'h1};
    a.shutPort = 6'h03;
    chk("resAct", a, resAct);
    {e.deny, e.shutdown} = 2'h3;
    wr(8'h0a, e, 1'h0);
    logReady <= 1'h0;
    send(frm(), 1'h1, 8'h0a);
    a = '0;
    {a.drop, a.shutdown, a.shutPort} = {1'h1, 1'h1, 6'h03};
    // Identifiers still travel with a denied frame; only their enables are cleared.
    {a.rateId, a.policerId, a.redirPort} = {4'h4, 7'h7f, 6'h05};
    chk("resAct", a, resAct);
    chk("logLost", 48'h1, logLost);
    logReady <= 1'h1;
    {e.deny, e.shutdown, e.redirPort} = {2'h0, 6'h28};
    wr(8'h0a, e, 1'h0);
    send(frm(), 1'h1, 8'h0a);
    chk("resAct.redirEn", 48'h0, resAct.redirEn);
  endtask

  task automatic t_mac();
    afc_destination_station_address_e md[4] = '{DM_GROUP_CAST, DM_ALL_CAST, DM_SINGLE_CAST, DM_SPECIFIC};
    logic [47:0] da[3] = '{48'h0100_0000_0005, 48'hffff_ffff_ffff, 48'h0200_0000_0002};
    afc_entry_s e;
    afc_frame_s f;
    e = ent(FT_ANY);
    e.destinationStationAddress = 48'h0200_0000_0002;
    f = frm();
    for (int m = 0; m < 4; m++)
    begin
      e.dstMode = md[m];
      wr(8'h0a, e, 1'h0);
      for (int k = 0; k < 3; k++)
      begin
        f.destinationStationAddress = da[k];
        send(f, k == ((m == 3) ? 2 : m), 8'h0a);
      end
    end
    e = ent(FT_ETYPE);
    e.srcSpecific = 1'h1;
    e.sourceStationAddress = 48'h0200_0000_0001;
    wr(8'h0a, e, 1'h0);
    send(frm(), 1'h1, 8'h0a);
    f = frm();
    f.sourceStationAddress = 48'h0200_0000_0009;
    send(f, 1'h0, 8'h00);
    e.ftype = FT_ANY;
    wr(8'h0a, e, 1'h0);
    send(f, 1'h1, 8'h0a);
  endtask

  task automatic t_count();
    strobe(1'h0, 1'h1);
    wr(8'h0a, ent(FT_ANY), 1'h0);
    wr(8'h0c, ent(FT_ANY), 1'h0);
    repeat (3)
      send(frm(), 1'h1, 8'h0a);
    rdCnt(8'h0a, 32'h0000_0003);
    rdCnt(8'h0c, 32'h0000_0000);
    strobe(1'h0, 1'h1);
    rdCnt(8'h0a, 32'h0000_0000);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'h1;
    rdCnt(8'h0a, 32'h0000_0000);
    t_port();
    t_policy();
    t_ftype();
    t_actions();
    t_mac();
    t_count();
    summarize();
  end
endmodule
